/* core/cig_regs.svh */
`ifndef CIG_REGS_SVH
`define CIG_REGS_SVH

// register byte offsets
`define CIG_PIN5_CTRL_OFS 12'h078
`define CIG_PIN4_CTRL_OFS 12'h1e0
`define CIG_IRQ_STATUS_OFS 12'h1e4
`define CIG_IRQ_MASK_OFS 12'h1e8
`define CIG_IRQ_CTRL_OFS 12'h1ec
`define CIG_PIN_IN_OFS 12'h1f0

// pin control fields
`define CIG_FN_MSB 13
`define CIG_FN_LSB 8
`define CIG_DIR_BIT 7
`define CIG_DRV_BIT 6
`define CIG_POL_BIT 5
`define CIG_LVL_BIT 4
`define CIG_PD_BIT 3
`define CIG_PU_BIT 2
`define CIG_MODE_BIT 1
`define CIG_DB_BIT 0

// reset values
`define CIG_PIN5_CTRL_RST 16'h01a0
`define CIG_PIN4_CTRL_RST 16'h0220
`define CIG_IRQ_MASK_RST 16'hffff
`define CIG_IRQ_CTRL_RST 16'h0000

// status bit positions
`define CIG_ST_SHORT 15
`define CIG_ST_MICDET 14
`define CIG_ST_SEQ 13
`define CIG_ST_LOCK 5
`define CIG_ST_PIN5 4
`define CIG_ST_PIN4 3

// irq control fields
`define CIG_CTL_IRQ_OUTPUT_POLARITY 0
`define CIG_CTL_MIC_INV 1
`define CIG_CTL_SHORT_INV 2
`define CIG_CTL_LOCK_INV 3

// debounce time and count
`define CIG_DB_TIME_NS 1000
`define CIG_CLK_NS 100
`define CIG_DB_CYCLES ((`CIG_DB_TIME_NS + `CIG_CLK_NS - 1) / `CIG_CLK_NS)

`endif

/* core/cig_pkg.sv */
package cig_pkg;
    // pin function codes
    typedef enum logic [5:0] {
        CIG_FN_OUT = 6'h00,
        CIG_FN_BCLK = 6'h01,
        CIG_FN_IRQ = 6'h02,
        CIG_FN_IN = 6'h03,
        CIG_FN_MICDET = 6'h04,
        CIG_FN_SHORT = 6'h05,
        CIG_FN_LOCK = 6'h08,
        CIG_FN_FLLCLK = 6'h09
    } cig_fn_t;

    // apb slave phase
    typedef enum logic [1:0] {
        CIG_BUS_IDLE,
        CIG_BUS_ACCESS,
        CIG_BUS_DONE
    } cig_bus_t;
endpackage

/* core/cig_pin_input.sv */
`timescale 1ns/1ps
`include "cig_regs.svh"

// conditions one pin input into a raw interrupt event
module cig_pin_input
    import cig_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin and configuration
    input wire logic pin_in,
    input wire logic debounce_en,
    input wire logic active_high,
    input wire logic edge_mode,
    // event out
    output logic event_out
);
    localparam logic [3:0] DB_MAX = 4'(`CIG_DB_CYCLES);

    logic stable_reg;
    logic [3:0] db_cnt_reg;
    logic prev_reg;
    logic active;

    // debounce filter: new level must hold DB_MAX cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_reg <= 1'b0;
            db_cnt_reg <= 4'h0;
        end else if (!debounce_en || pin_in == stable_reg) begin
            stable_reg <= debounce_en ? stable_reg : pin_in;
            db_cnt_reg <= 4'h0;
        end else if (db_cnt_reg == DB_MAX - 4'h1) begin
            stable_reg <= pin_in;
            db_cnt_reg <= 4'h0;
        end else begin
            db_cnt_reg <= db_cnt_reg + 4'h1;
        end
    end

    assign active = active_high ? stable_reg : ~stable_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= active;
        end
    end

    assign event_out = edge_mode ? (active & ~prev_reg) : active;
endmodule

/* core/cig_irq_ctrl.sv */
`timescale 1ns/1ps
`include "cig_regs.svh"

// Operation
// - pins, mic detectors, lock and sequencer all raise events
// - one status bit per source in a single status register
// - status register readable at any time
// - interrupt is OR of status bits with mask bit clear
// - status bit latches on event, clears when status is read
// - interrupt stays until all unmasked set bits are read
// - still-active source keeps its status bit set after read
// - one mask bit per source; set excludes it from interrupt
// - masked bits still latch but never drive interrupt
// - pin polarity bit 5, reset 1, 1 is active high
// - mic current and short events each have an invert control
// - lock event invert chooses locked or not-locked
// - interrupt active high after reset, polarity bit inverts
// - interrupt routable to pins; pin4 function resets to 2h
// - pin5 function bits 13:8 reset 01h: out, bclk, irq, input
// - codes 04h and 05h output mic current and short status
// - codes 08h lock indication, 09h loop clock
// - codes 06h, 07h, 0Ah-3Fh reserved, pin drives low
// - bit 4 level in output mode, bit 7 direction, bit 6 drive
// - bit 3 pull-down enable, reset 0
// - bit 2 pull-up enable, reset 0
// - bit 0 debounce, bit 1 edge mode, both reset 0
// - sequencer done sets its status bit
// - mask bits reset to 1
module cig_irq_ctrl
    import cig_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event sources, and clocks routed to the pins
    input wire logic mic_current_det,
    input wire logic mic_short_det,
    input wire logic fll_lock,
    input wire logic fll_clk,
    input wire logic bit_clk,
    input wire logic seq_done,
    // pin 5
    input wire logic pin5_in,
    output logic pin5_out,
    output logic pin5_oe_n,
    output logic pin5_pullup_en,
    output logic pin5_pulldown_en,
    // pin 4
    input wire logic pin4_in,
    output logic pin4_out,
    output logic pin4_oe_n,
    output logic pin4_pullup_en,
    output logic pin4_pulldown_en
);
    logic [15:0] pin5_ctrl_reg;
    logic [15:0] pin4_ctrl_reg;
    logic [15:0] status_reg;
    logic [15:0] status_next;
    logic [15:0] mask_reg;
    logic [3:0] irq_ctrl_reg;
    logic [15:0] src_event;
    logic pin5_event;
    logic pin4_event;
    logic irq_raw;
    logic irq_level;
    logic wr_en;
    logic rd_en;
    logic status_rd;
    logic pin5_drv;
    logic pin5_oe_drv;
    logic pin4_drv;
    logic pin4_oe_drv;
    cig_bus_t bus_state;

    // decode register hit
    function automatic logic addr_known(input logic [11:0] a);
        return a == `CIG_PIN5_CTRL_OFS || a == `CIG_PIN4_CTRL_OFS ||
               a == `CIG_IRQ_STATUS_OFS || a == `CIG_IRQ_MASK_OFS ||
               a == `CIG_IRQ_CTRL_OFS || a == `CIG_PIN_IN_OFS;
    endfunction

    // pin function output mux, shared by both pins
    function automatic logic fn_value(input logic [15:0] ctrl, input logic irq_v,
                                      input logic micdet, input logic shrt,
                                      input logic lock, input logic fclk,
                                      input logic bclk);
        logic v;
        v = 1'b0;
        case (ctrl[`CIG_FN_MSB:`CIG_FN_LSB])
            // level applies in output function only
            CIG_FN_OUT: v = ctrl[`CIG_LVL_BIT];
            CIG_FN_BCLK: v = bclk;
            CIG_FN_IRQ: v = irq_v;
            CIG_FN_MICDET: v = micdet;
            CIG_FN_SHORT: v = shrt;
            CIG_FN_LOCK: v = lock;
            CIG_FN_FLLCLK: v = fclk;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    // apb phases: one wait state, answer after setup plus two cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state <= CIG_BUS_IDLE;
        end else begin
            case (bus_state)
                CIG_BUS_IDLE: bus_state <= (psel && !penable) ? CIG_BUS_ACCESS : CIG_BUS_IDLE;
                CIG_BUS_ACCESS: bus_state <= CIG_BUS_DONE;
                CIG_BUS_DONE: bus_state <= CIG_BUS_IDLE;
                default: bus_state <= CIG_BUS_IDLE;
            endcase
        end
    end

    // transfer completes in the cycle pready is high
    assign wr_en = pready && psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite && bus_state == CIG_BUS_ACCESS;
    assign status_rd = pready && psel && penable && !pwrite && paddr == `CIG_IRQ_STATUS_OFS;

    // answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= bus_state == CIG_BUS_ACCESS;
            pslverr <= bus_state == CIG_BUS_ACCESS && !addr_known(paddr);
            if (rd_en) begin
                case (paddr)
                    `CIG_PIN5_CTRL_OFS: prdata <= {16'h0000, pin5_ctrl_reg};
                    `CIG_PIN4_CTRL_OFS: prdata <= {16'h0000, pin4_ctrl_reg};
                    `CIG_IRQ_STATUS_OFS: prdata <= {16'h0000, status_reg};
                    `CIG_IRQ_MASK_OFS: prdata <= {16'h0000, mask_reg};
                    `CIG_IRQ_CTRL_OFS: prdata <= {28'h0000000, irq_ctrl_reg};
                    `CIG_PIN_IN_OFS: prdata <= {30'h0, pin5_in, pin4_in};
                    default: prdata <= 32'h0000_0000;
                endcase
            end else if (bus_state == CIG_BUS_DONE) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // control registers; unused field bits read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin5_ctrl_reg <= `CIG_PIN5_CTRL_RST;
            pin4_ctrl_reg <= `CIG_PIN4_CTRL_RST;
            irq_ctrl_reg <= 4'(`CIG_IRQ_CTRL_RST);
        end else if (wr_en) begin
            if (paddr == `CIG_PIN5_CTRL_OFS) begin
                pin5_ctrl_reg <= pwdata[15:0] & 16'h3fff;
            end
            if (paddr == `CIG_PIN4_CTRL_OFS) begin
                pin4_ctrl_reg <= pwdata[15:0] & 16'h3fff;
            end
            if (paddr == `CIG_IRQ_CTRL_OFS) begin
                irq_ctrl_reg <= pwdata[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= `CIG_IRQ_MASK_RST;
        end else if (wr_en && paddr == `CIG_IRQ_MASK_OFS) begin
            mask_reg <= pwdata[15:0];
        end
    end

    // pin input conditioners
    // debounce and trigger mode bits
    cig_pin_input u_pin5 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(pin5_in),
        .debounce_en(pin5_ctrl_reg[`CIG_DB_BIT]),
        .active_high(pin5_ctrl_reg[`CIG_POL_BIT]),
        .edge_mode(pin5_ctrl_reg[`CIG_MODE_BIT]),
        .event_out(pin5_event)
    );

    cig_pin_input u_pin4 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(pin4_in),
        .debounce_en(pin4_ctrl_reg[`CIG_DB_BIT]),
        .active_high(pin4_ctrl_reg[`CIG_POL_BIT]),
        .edge_mode(pin4_ctrl_reg[`CIG_MODE_BIT]),
        .event_out(pin4_event)
    );

    always_comb begin
        src_event = 16'h0000;
        src_event[`CIG_ST_SHORT] = mic_short_det ^ irq_ctrl_reg[`CIG_CTL_SHORT_INV];
        src_event[`CIG_ST_MICDET] = mic_current_det ^ irq_ctrl_reg[`CIG_CTL_MIC_INV];
        src_event[`CIG_ST_SEQ] = seq_done;
        src_event[`CIG_ST_LOCK] = fll_lock ^ irq_ctrl_reg[`CIG_CTL_LOCK_INV];
        // pins count only when configured as input
        src_event[`CIG_ST_PIN5] = pin5_event && pin5_ctrl_reg[`CIG_DIR_BIT];
        src_event[`CIG_ST_PIN4] = pin4_event && pin4_ctrl_reg[`CIG_DIR_BIT];
    end

    // clear on read, an active source wins over the clear
    assign status_next = (status_rd ? 16'h0000 : status_reg) | src_event;

    // single status register, latches regardless of mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 16'h0000;
        end else begin
            status_reg <= status_next;
        end
    end

    // unmasked OR, holds until read clears
    assign irq_raw = |(status_reg & ~mask_reg);
    assign irq_level = irq_raw ^ irq_ctrl_reg[`CIG_CTL_IRQ_OUTPUT_POLARITY];

    // routing to either pin via its function field
    assign pin5_drv = fn_value(pin5_ctrl_reg, irq_level, mic_current_det, mic_short_det,
                               fll_lock, fll_clk, bit_clk);
    assign pin4_drv = fn_value(pin4_ctrl_reg, irq_level, mic_current_det, mic_short_det,
                               fll_lock, fll_clk, bit_clk);
    // direction and open-drain: open-drain only pulls low
    assign pin5_oe_drv = !pin5_ctrl_reg[`CIG_DIR_BIT] &&
                         (!pin5_ctrl_reg[`CIG_DRV_BIT] || !pin5_drv);
    assign pin4_oe_drv = !pin4_ctrl_reg[`CIG_DIR_BIT] &&
                         (!pin4_ctrl_reg[`CIG_DRV_BIT] || !pin4_drv);

    // registered pin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin5_out <= 1'b0;
            pin5_oe_n <= 1'b1;
            pin4_out <= 1'b0;
            pin4_oe_n <= 1'b1;
            pin5_pullup_en <= 1'b0;
            pin5_pulldown_en <= 1'b0;
            pin4_pullup_en <= 1'b0;
            pin4_pulldown_en <= 1'b0;
        end else begin
            pin5_out <= pin5_drv;
            pin5_oe_n <= !pin5_oe_drv;
            pin4_out <= pin4_drv;
            pin4_oe_n <= !pin4_oe_drv;
            pin5_pulldown_en <= pin5_ctrl_reg[`CIG_PD_BIT];
            pin4_pulldown_en <= pin4_ctrl_reg[`CIG_PD_BIT];
            pin5_pullup_en <= pin5_ctrl_reg[`CIG_PU_BIT];
            pin4_pullup_en <= pin4_ctrl_reg[`CIG_PU_BIT];
        end
    end

    // checks
    sequence s_seq_evt;
        seq_done;
    endsequence

    sequence s_seq_seen;
        ##1 status_reg[`CIG_ST_SEQ];
    endsequence

    chk_status_latch: assert property (@(posedge pclk) disable iff (!presetn)
        s_seq_evt |-> s_seq_seen)
        else $error("sequencer event did not latch");

    chk_status_hold: assert property (@(posedge pclk) disable iff (!presetn)
        status_reg[`CIG_ST_SEQ] && !status_rd |=> status_reg[`CIG_ST_SEQ])
        else $error("status bit lost without read");

    chk_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
        status_rd && !seq_done |=> !status_reg[`CIG_ST_SEQ])
        else $error("status bit not cleared by read");

    chk_active_keep: assert property (@(posedge pclk) disable iff (!presetn)
        status_rd && fll_lock && !irq_ctrl_reg[`CIG_CTL_LOCK_INV]
        |=> status_reg[`CIG_ST_LOCK])
        else $error("active source lost on read");

    chk_irq_or: assert property (@(posedge pclk) disable iff (!presetn)
        (status_reg & ~mask_reg) != 16'h0000 && !irq_ctrl_reg[`CIG_CTL_IRQ_OUTPUT_POLARITY] |-> irq_level)
        else $error("interrupt not the unmasked or");

    chk_mask_block: assert property (@(posedge pclk) disable iff (!presetn)
        mask_reg == 16'hffff |-> !irq_raw)
        else $error("masked status raised interrupt");

    chk_irq_route: assert property (@(posedge pclk) disable iff (!presetn)
        pin4_ctrl_reg[`CIG_FN_MSB:`CIG_FN_LSB] == CIG_FN_IRQ && $stable(pin4_ctrl_reg)
        |=> pin4_out == $past(irq_level))
        else $error("interrupt not on routed pin");

    chk_out_level: assert property (@(posedge pclk) disable iff (!presetn)
        pin5_ctrl_reg[`CIG_FN_MSB:`CIG_FN_LSB] == CIG_FN_OUT && !pin5_ctrl_reg[`CIG_DIR_BIT]
        && !pin5_ctrl_reg[`CIG_DRV_BIT] |=> pin5_out == $past(pin5_ctrl_reg[`CIG_LVL_BIT])
        && !pin5_oe_n)
        else $error("programmed output level wrong");

    chk_mask_reset: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> mask_reg == 16'hffff)
        else $error("mask not set after reset");
endmodule

/* sim/cig_host_pin.sv */
`timescale 1ns/1ps

// host side of one pin: drives it when asked and sees the resolved level
module cig_host_pin (
    // clock
    input wire logic pclk,
    // design side of the pin
    input wire logic pin_out,
    input wire logic pin_oe_n,
    input wire logic pull_up,
    input wire logic pull_down,
    // host drive
    input wire logic host_en,
    input wire logic host_val,
    // resolved level
    output logic pin_wire
);
    logic last_reg;

    // remember the level so a floating wire can wander
    always_ff @(posedge pclk) begin
        last_reg <= pin_wire;
    end

    // a floating wire toggles, so a stale value never passes for a drive
    always_comb begin
        if (!pin_oe_n) begin
            pin_wire = pin_out;
        end else if (host_en) begin
            pin_wire = host_val;
        end else if (pull_up) begin
            pin_wire = 1'b1;
        end else if (pull_down) begin
            pin_wire = 1'b0;
        end else begin
            pin_wire = ~last_reg;
        end
    end
endmodule

/* sim/test_codec_irq_and_gpio5_ctrl.sv */
`timescale 1ns/1ps
`include "cig_regs.svh"

module test_codec_irq_and_gpio5_ctrl;
    localparam logic [11:0] ofs_p5 = `CIG_PIN5_CTRL_OFS;
    localparam logic [11:0] ofs_p4 = `CIG_PIN4_CTRL_OFS;
    localparam logic [11:0] ofs_st = `CIG_IRQ_STATUS_OFS;
    localparam logic [11:0] ofs_mk = `CIG_IRQ_MASK_OFS;
    localparam logic [11:0] ofs_ct = `CIG_IRQ_CTRL_OFS;
    localparam logic [31:0] inv_bit [3] = '{32'h4000, 32'h8000, 32'h0020};
    localparam logic [5:0] fn_code [10] = '{6'h02, 6'h04, 6'h05, 6'h01, 6'h08, 6'h09,
        6'h06, 6'h07, 6'h0a, 6'h3f};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, pin5_in, pin4_in;
    logic mic_current_det = 1'b0, mic_short_det = 1'b0, fll_lock = 1'b0;
    logic fll_clk = 1'b0, bit_clk = 1'b0, seq_done = 1'b0;
    logic pin5_out, pin5_oe_n, pin5_pullup_en, pin5_pulldown_en;
    logic pin4_out, pin4_oe_n, pin4_pullup_en, pin4_pulldown_en;
    logic host4_en = 1'b1, host5_en = 1'b1, host5_val = 1'b0;
    logic [15:0] lfsr_reg = 16'hca7c;
    logic [32:0] exp_q [$];
    logic [8:0] obs;
    int n_fail = 0;
    int tests_run = 0;

    cig_irq_ctrl i_cig_irq_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mic_current_det, .mic_short_det, .fll_lock, .fll_clk,
        .bit_clk, .seq_done, .pin5_in, .pin5_out, .pin5_oe_n, .pin5_pullup_en,
        .pin5_pulldown_en, .pin4_in, .pin4_out, .pin4_oe_n, .pin4_pullup_en, .pin4_pulldown_en);
    cig_host_pin i_cig_host_pin4 (.pclk, .pin_out(pin4_out), .pin_oe_n(pin4_oe_n),
        .pull_up(pin4_pullup_en), .pull_down(pin4_pulldown_en), .host_en(host4_en),
        .host_val(1'b0), .pin_wire(pin4_in));
    cig_host_pin i_cig_host_pin5 (.pclk, .pin_out(pin5_out), .pin_oe_n(pin5_oe_n),
        .pull_up(pin5_pullup_en), .pull_down(pin5_pulldown_en), .host_en(host5_en),
        .host_val(host5_val), .pin_wire(pin5_in));
    // observed pins, picked by index in the pin checks
    assign obs = {pin4_pulldown_en, pin4_pullup_en, pin4_oe_n, pin5_in, pin4_in, pin5_oe_n,
        pin5_pullup_en, pin5_pulldown_en, pin5_out};

    // clock at 10 MHz
    initial begin
        forever #50 pclk = ~pclk;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one transfer; the answer is noted for the monitor
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [32:0] exp);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        exp_q.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no cycle count assumed; only the hang guard ends this wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0, {1'b0, d});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // let a change settle, look at a pin mid-cycle, return on an edge
    task automatic pchk(input string name, input int i, input logic exp);
        tick(3);
        @(negedge pclk);
        check(name, {32'h0, obs[i]}, {32'h0, exp});
        @(posedge pclk);
    endtask

    // the oldest note against what the slave answered; writes show only the error flag
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (pwrite) begin
                check("write response", {pslverr, 32'h0}, {exp_q[0][32], 32'h0});
            end else begin
                check("read data", {pslverr, prdata}, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end

    // hang guard, far beyond the expected run
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, then an unmapped place refused both ways
        rd(ofs_p5, 32'h01a0);
        rd(ofs_p4, 32'h0220);
        rd(ofs_mk, 32'hffff);
        rd(ofs_ct, 32'h0);
        rd(ofs_st, 32'h0);
        apb(1'b0, 12'h100, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h100, 32'h5a5a, {1'b1, 32'h0});
        // interrupt on pin 4, idle low
        wr(ofs_p4, 32'h0200);
        host4_en <= 1'b0;
        pchk("pin4 idle", 4, 1'b0);
        // masked event latches but stays off the output
        mic_current_det <= 1'b1;
        @(posedge pclk);
        mic_current_det <= 1'b0;
        pchk("pin4 masked", 4, 1'b0);
        rd(ofs_st, 32'h4000);
        rd(ofs_st, 32'h0);
        wr(ofs_mk, 32'h0);
        seq_done <= 1'b1;
        @(posedge pclk);
        seq_done <= 1'b0;
        pchk("pin4 seq", 4, 1'b1);
        rd(ofs_st, 32'h2000);
        pchk("pin4 cleared", 4, 1'b0);
        // a source still active survives the read
        fll_lock <= 1'b1;
        tick(3);
        rd(ofs_st, 32'h20);
        rd(ofs_st, 32'h20);
        pchk("pin4 held", 4, 1'b1);
        fll_lock <= 1'b0;
        tick(3);
        rd(ofs_st, 32'h20);
        rd(ofs_st, 32'h0);
        // inverted events fire with every source idle
        for (int i = 0; i < 3; i++) begin
            wr(ofs_ct, 32'h2 << i);
            tick(3);
            rd(ofs_st, inv_bit[i]);
            wr(ofs_ct, 32'h0);
            tick(3);
            rd(ofs_st, inv_bit[i]);
            rd(ofs_st, 32'h0);
        end
        wr(ofs_ct, 32'h1);
        pchk("pin4 inverted", 4, 1'b1);
        wr(ofs_ct, 32'h0);
        lfsr_reg = lfsr_next(lfsr_reg);
        wr(ofs_mk, {16'h0, lfsr_reg});
        rd(ofs_mk, {16'h0, lfsr_reg});
        wr(ofs_mk, 32'h0);
        // pin 5 input: edge, level, then active low
        wr(ofs_p5, 32'h03a2);
        tick(3);
        rd(ofs_st, 32'h0);
        host5_val <= 1'b1;
        tick(3);
        rd(ofs_st, 32'h10);
        rd(ofs_st, 32'h0);
        wr(ofs_p5, 32'h03a0);
        tick(3);
        rd(ofs_st, 32'h10);
        rd(ofs_st, 32'h10);
        host5_val <= 1'b0;
        tick(3);
        rd(ofs_st, 32'h10);
        rd(ofs_st, 32'h0);
        wr(ofs_p5, 32'h0380);
        tick(3);
        rd(ofs_st, 32'h10);
        host5_val <= 1'b1;
        tick(3);
        rd(ofs_st, 32'h10);
        rd(ofs_st, 32'h0);
        // debounce hides a short random glitch, passes a steady level
        wr(ofs_p5, 32'h0381);
        lfsr_reg = lfsr_next(lfsr_reg);
        host5_val <= 1'b0;
        tick(1 + lfsr_reg[2:0]);
        host5_val <= 1'b1;
        tick(15);
        rd(ofs_st, 32'h0);
        host5_val <= 1'b0;
        tick(5);
        rd(ofs_st, 32'h0);
        tick(10);
        rd(ofs_st, 32'h10);
        // pin 5 driven by the block
        host5_en <= 1'b0;
        lfsr_reg = lfsr_next(lfsr_reg);
        wr(ofs_p5, {27'h0, lfsr_reg[0], 4'h0});
        pchk("pin5 level", 5, lfsr_reg[0]);
        wr(ofs_p5, 32'h0054);
        pchk("pin5 od high", 5, 1'b1);
        pchk("pin5 od off", 3, 1'b1);
        pchk("pullup", 2, 1'b1);
        wr(ofs_p5, 32'h0048);
        pchk("pin5 od low", 5, 1'b0);
        pchk("pin5 od drive", 3, 1'b0);
        pchk("pulldown", 1, 1'b1);
        wr(ofs_p5, 32'h0090);
        pchk("pin5 input dir", 3, 1'b1);
        // function codes with every source high, then all but 02h, 04h and 05h with every source low
        {mic_current_det, mic_short_det, fll_lock, fll_clk, bit_clk} <= 5'h1f;
        for (int p = 0; p < 2; p++) begin
            for (int k = 3 * p; k < 10; k++) begin
                wr(ofs_p5, {18'h0, fn_code[k], 8'h00});
                pchk("pin5 function", 0, p == 0 && k < 6);
            end
            {mic_current_det, mic_short_det, fll_lock, fll_clk, bit_clk} <= 5'h0;
        end
        // the loop latched both detectors and lock; the floating pin 5 input latched before it, while pin 5 was an input
        rd(ofs_st, 32'hc030);
        // pin 4 turned into a pulled input; driven high first so no false level
        wr(ofs_ct, 32'h1);
        wr(ofs_p4, 32'h0284);
        wr(ofs_ct, 32'h0);
        pchk("pin4 released", 6, 1'b1);
        pchk("pin4 pullup", 7, 1'b1);
        rd(`CIG_PIN_IN_OFS, 32'h1);
        rd(ofs_st, 32'h0);
        wr(ofs_p4, 32'h0288);
        pchk("pin4 pulldown", 8, 1'b1);
        rd(ofs_st, 32'h8);
        rd(ofs_st, 32'h8);
        print_verdict();
    end
endmodule
